// ### hdl/acl_cfg.svh
// Offsets, field positions, reset values and limits of the criteria lookup block
`ifndef ACL_CFG_SVH
`define ACL_CFG_SVH
`define ACL_OFS_CMD 8'h00
`define ACL_OFS_ARG0 8'h04
`define ACL_OFS_ARG1 8'h08
`define ACL_OFS_ARG2 8'h0c
`define ACL_OFS_STATUS 8'h10
`define ACL_OFS_RES0 8'h14
`define ACL_OFS_RES1 8'h18
`define ACL_OFS_RES2 8'h1c
`define ACL_OFS_DATE 8'h20
`define ACL_OFS_SEQ 8'h24
`define ACL_OFS_LOADED 8'h28
`define ACL_CMD_OP_LSB 0
`define ACL_CMD_ARG_LSB 4
`define ACL_CMD_IDX_LSB 8
`define ACL_CMD_SRC_LSB 16
`define ACL_CMD_ENC_BIT 18
`define ACL_RST_STATE '0
`define ACL_NO_DATE 16'h0000
`define ACL_WILD 8'hff
`define ACL_OPEN_MAX 8'hff
`define ACL_BASE_LOADED 3'h7
`define ACL_PHYS_ID 32'h0000_0a11
`endif

// ### hdl/acl_pkg.sv
// Types and shared decode functions of the criteria lookup block
package acl_pkg;
`include "acl_cfg.svh"

	typedef enum logic [1:0] {
		ACL_ST_ZERO = 2'b00,
		ACL_ST_ONE = 2'b01,
		ACL_ST_TWO = 2'b10,
		ACL_ST_THREE = 2'b11
	} acl_op_state_t;

	typedef enum logic [3:0] {
		ACL_OP_NONE = 4'h0,
		ACL_OP_BEGIN = 4'h1,
		ACL_OP_AUTH = 4'h2,
		ACL_OP_SEAL = 4'h3,
		ACL_OP_POLL = 4'h4,
		ACL_OP_DELETE = 4'h5,
		ACL_OP_LOAD = 4'h6,
		ACL_OP_PRODUCT = 4'h7
	} acl_opcode_t;

	typedef enum logic [3:0] {
		ACL_RS_OK = 4'h0,
		ACL_RS_STATE = 4'h1,
		ACL_RS_LIMIT = 4'h2,
		ACL_RS_NOMATCH = 4'h3,
		ACL_RS_ORDER = 4'h4,
		ACL_RS_SOURCE = 4'h5,
		ACL_RS_OPCODE = 4'h6
	} acl_result_t;

	typedef enum logic [3:0] {
		ACL_TB_CONFIG = 4'h0,
		ACL_TB_HEADER = 4'h1,
		ACL_TB_ASYM = 4'h2,
		ACL_TB_CARD = 4'h3,
		ACL_TB_ACCESS_KEYS = 4'h4,
		ACL_TB_PRODUCTS = 4'h5,
		ACL_TB_PRODUCT_KEYS = 4'h6,
		ACL_TB_INSTANCES = 4'h7
	} acl_table_t;

	typedef enum logic [1:0] {
		ACL_SRC_NONE = 2'b00,
		ACL_SRC_ASSET = 2'b01,
		ACL_SRC_SECURITY = 2'b10,
		ACL_SRC_OTHER = 2'b11
	} acl_source_t;

	typedef struct packed {
		logic used;
		logic [31:0] codes;
		logic [15:0] from_date;
		logic [15:0] until_date;
	} acl_card_rec_t;

	typedef struct packed {
		logic used;
		logic [31:0] sel;
		logic [7:0] oper;
		logic own;
		logic create;
		logic [15:0] from_date;
		logic [15:0] until_date;
	} acl_prod_rec_t;

	typedef struct packed {
		acl_prod_rec_t [3:0] rec;
	} acl_prod_state_t;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		acl_op_state_t op_state;
		acl_result_t result;
		logic [31:0] arg0;
		logic [31:0] arg1;
		logic [31:0] arg2;
		logic [31:0] res0;
		logic [31:0] res1;
		logic [31:0] res2;
		logic [31:0] seq;
		logic [31:0] header;
		logic [31:0] cfg_key;
		logic [31:0] sess;
		logic [15:0] today;
		logic [7:0] batch_limit;
		logic [7:0] open_batches;
		logic [7:0] loaded;
		acl_card_rec_t [3:0] card;
		logic [3:0][31:0] ro_key;
		logic [3:0][31:0] rw_key;
		logic [3:0][31:0] pkey;
		logic [3:0][31:0] inst;
	} acl_top_state_t;

	// Record usable from its start date through its end date, zero meaning open
	function automatic logic acl_date_ok(input logic [15:0] from_d, input logic [15:0] until_d,
			input logic [15:0] today);
		return (from_d == `ACL_NO_DATE || today >= from_d) &&
			(until_d == `ACL_NO_DATE || today <= until_d);
	endfunction

	// Lowest numbered hit wins, so tables are searched first to last
	function automatic logic [2:0] acl_first(input logic [3:0] hits);
		logic [2:0] r;
		r = 3'b000;
		for (int i = 3; i >= 0; i--) begin
			if (hits[i]) begin
				r = {1'b1, 2'(i)};
			end
		end
		return r;
	endfunction
endpackage

// ### hdl/acl_mix.sv
// Keyed word mixer used for seals, session codes and reference encryption
`timescale 1ns/1ns
module acl_mix (
	// Operands
	input wire logic [31:0] data_in,
	input wire logic [31:0] key_in,
	// Result
	output logic [31:0] mixed_out
);
	logic [31:0] r1;

	// Two rounds of add, rotate and xor
	always_comb begin
		r1 = (data_in ^ key_in) + {key_in[15:0], key_in[31:16]};
		mixed_out = {r1[24:0], r1[31:25]} ^ (r1 + 32'h9e37_79b9);
	end
endmodule

// ### hdl/acl_prod_match.sv
// Accepted-products table with ordered wildcard search
`timescale 1ns/1ns
module acl_prod_match
	import acl_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_in,
	// Record write
	input wire logic wr_en_in,
	input wire logic [1:0] wr_idx_in,
	input wire acl_prod_rec_t wr_rec_in,
	// Query
	input wire logic [15:0] today_in,
	input wire logic [31:0] sel_in,
	input wire logic [7:0] oper_in,
	// Answer
	output logic hit_out,
	output logic [1:0] idx_out,
	output logic own_out,
	output logic create_out
);
	acl_prod_state_t s_q;
	acl_prod_state_t s_d;
	logic [3:0] qual;
	logic [2:0] first;

	// Record qualification: owner, revision, key, operator, dates, then type wildcards
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_rec
			assign qual[gi] = s_q.rec[gi].used &&
				acl_date_ok(s_q.rec[gi].from_date, s_q.rec[gi].until_date, today_in) &&
				s_q.rec[gi].sel[31:24] == sel_in[31:24] &&
				s_q.rec[gi].sel[7:0] == sel_in[7:0] &&
				s_q.rec[gi].oper == oper_in &&
				(s_q.rec[gi].sel[23:16] == `ACL_WILD ||
				(s_q.rec[gi].sel[23:16] == sel_in[23:16] &&
				(s_q.rec[gi].sel[15:8] == `ACL_WILD ||
				s_q.rec[gi].sel[15:8] == sel_in[15:8])));
		end
	endgenerate

	// First qualifying record in table order
	always_comb begin
		first = acl_first(qual);
		hit_out = first[2];
		idx_out = first[1:0];
		own_out = s_q.rec[first[1:0]].own;
		create_out = s_q.rec[first[1:0]].create;
	end

	// Table update
	always_comb begin
		s_d = s_q;
		if (wr_en_in) begin
			s_d.rec[wr_idx_in] = wr_rec_in;
		end
	end

	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			s_q <= `ACL_RST_STATE;
		end else begin
			s_q <= s_d;
		end
	end
endmodule

// ### hdl/acl_lookup.sv
// Command gating and acceptance criteria lookup with an APB register slave
`timescale 1ns/1ns

// Overview of operation
// - Medium authentication only in operating state three
// - Secure mode adds session-unique message code
// - Sealing only in operating state two or three
// - Seal covers message, source identity, sequence number
// - Sealing also returns current batch header
// - Seal only while open batches below limit
// - Shell reference encrypted, diversified by operator identifier
// - Criteria tables need configuration, header, asymmetric keyset
// - Records usable between valid-from and valid-until dates
// - Zero dates mean valid now, never expiring
// - Medium access needs full card codes match
// - Access keysets hold separate read-only and read/write keys
// - Access keysets updated only from security management
// - Product key selected by concatenated identifiers
// - Instance identity from physical or proxy module
// - Accepted products updated only from asset management
// - Product keysets updated only from security management
// - Product search in order, first match wins
// - Subtype wildcard covers remaining subtypes of type
// - Type wildcard covers all remaining owner combinations
// - Sensitive tables need encrypted security management messages
module acl_lookup
	import acl_pkg::*;
#(
	// Physical module identity; value is arbitrary
	parameter logic [31:0] PHYS_ID = `ACL_PHYS_ID
) (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_in,
	// APB slave
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out
);
	acl_top_state_t s_q;
	acl_top_state_t s_d;
	acl_opcode_t op;
	acl_table_t tbl;
	acl_source_t src;
	logic [1:0] idx;
	logic enc;
	logic commit;
	logic src_ok;
	logic [3:0] card_q;
	logic [2:0] card_first;
	logic [1:0] cidx;
	logic [31:0] seq_n;
	logic [31:0] auth_mac;
	logic [31:0] src_mix;
	logic [31:0] seal;
	logic [31:0] ref_enc;
	logic [31:0] hdr_n;
	logic [31:0] rd_word;
	logic [31:0] prod_sel;
	logic prod_wr;
	logic prod_hit;
	logic [1:0] prod_idx;
	logic prod_own;
	logic prod_create;
	acl_prod_rec_t prod_rec;

	// True for every offset that the slave decodes
	function automatic logic acl_mapped(input logic [7:0] a);
		case (a)
			`ACL_OFS_CMD, `ACL_OFS_ARG0, `ACL_OFS_ARG1, `ACL_OFS_ARG2,
			`ACL_OFS_STATUS, `ACL_OFS_RES0, `ACL_OFS_RES1, `ACL_OFS_RES2,
			`ACL_OFS_DATE, `ACL_OFS_SEQ, `ACL_OFS_LOADED: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction

	// Security-sensitive tables: all but card codes and accepted products
	function automatic logic acl_sensitive(input acl_table_t t);
		return t != ACL_TB_CARD && t != ACL_TB_PRODUCTS;
	endfunction

	// Operating states in which a gated command may run
	function automatic logic acl_state_ok(input acl_opcode_t o, input acl_op_state_t st);
		case (o)
			ACL_OP_AUTH: return st == ACL_ST_THREE;
			ACL_OP_SEAL: return st == ACL_ST_TWO || st == ACL_ST_THREE;
			ACL_OP_PRODUCT: return st == ACL_ST_THREE;
			default: return 1'b1;
		endcase
	endfunction

	// Outputs straight from the state flops
	assign prdata_out = s_q.prdata;
	assign pready_out = s_q.pready;
	assign pslverr_out = s_q.pslverr;

	// Card codes qualification, one term per record
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_card
			assign card_q[gi] = s_q.card[gi].used &&
				s_q.card[gi].codes == s_q.arg0 &&
				acl_date_ok(s_q.card[gi].from_date, s_q.card[gi].until_date, s_q.today);
		end
	endgenerate

	// Card match, sequence and product query words
	always_comb begin
		card_first = acl_first(card_q);
		cidx = card_first[1:0];
		seq_n = s_q.seq + 32'h1;
		// Issuer comes from the product group when the terminal says so
		prod_sel = {(s_q.arg1[16] ? s_q.arg0[31:24] : s_q.arg1[15:8]),
			s_q.arg0[23:0]};
		// Record image written by an accepted-products load
		prod_rec.used = 1'b1;
		prod_rec.sel = s_q.arg0;
		prod_rec.oper = s_q.arg1[7:0];
		prod_rec.own = s_q.arg1[8];
		prod_rec.create = s_q.arg1[9];
		prod_rec.from_date = s_q.arg2[31:16];
		prod_rec.until_date = s_q.arg2[15:0];
	end

	// Session code over the challenge, keyed per session
	acl_mix u_auth (
		.data_in(s_q.arg1),
		.key_in(s_q.ro_key[cidx] ^ (s_q.sess + 32'h1)),
		.mixed_out(auth_mac)
	);

	// Message combined with the module's source identity
	acl_mix u_src (
		.data_in(s_q.arg0),
		.key_in(PHYS_ID),
		.mixed_out(src_mix)
	);

	// Seal over message, identity and next sequence number
	acl_mix u_seal (
		.data_in(src_mix ^ seq_n),
		.key_in(s_q.cfg_key),
		.mixed_out(seal)
	);

	// Header advances by each new seal; the same word goes back to the terminal
	assign hdr_n = s_q.header ^ seal;

	// Shell reference encrypted under the shell's operator identifier
	acl_mix u_ref (
		.data_in(s_q.arg1),
		.key_in({4{s_q.arg2[7:0]}} ^ s_q.cfg_key),
		.mixed_out(ref_enc)
	);

	// Accepted-products table and search
	acl_prod_match u_prod (
		.sys_clk_in(sys_clk_in),
		.rst_in(rst_in),
		.wr_en_in(prod_wr),
		.wr_idx_in(idx),
		.wr_rec_in(prod_rec),
		.today_in(s_q.today),
		.sel_in(prod_sel),
		.oper_in(s_q.arg1[7:0]),
		.hit_out(prod_hit),
		.idx_out(prod_idx),
		.own_out(prod_own),
		.create_out(prod_create)
	);

	// Read data multiplexer
	always_comb begin
		case (paddr_in)
			`ACL_OFS_ARG0: rd_word = s_q.arg0;
			`ACL_OFS_ARG1: rd_word = s_q.arg1;
			`ACL_OFS_ARG2: rd_word = s_q.arg2;
			`ACL_OFS_STATUS: rd_word = {16'h0000, s_q.open_batches, s_q.result, 2'b00,
				s_q.op_state};
			`ACL_OFS_RES0: rd_word = s_q.res0;
			`ACL_OFS_RES1: rd_word = s_q.res1;
			`ACL_OFS_RES2: rd_word = s_q.res2;
			`ACL_OFS_DATE: rd_word = {16'h0000, s_q.today};
			`ACL_OFS_SEQ: rd_word = s_q.seq;
			`ACL_OFS_LOADED: rd_word = {24'h000000, s_q.loaded};
			default: rd_word = 32'h0000_0000;
		endcase
	end

	// Bus handshake, register writes and command execution
	always_comb begin
		s_d = s_q;
		// Command word fields, decoded on every cycle
		op = acl_opcode_t'(pwdata_in[`ACL_CMD_OP_LSB +: 4]);
		tbl = acl_table_t'(pwdata_in[`ACL_CMD_ARG_LSB +: 4]);
		idx = pwdata_in[`ACL_CMD_IDX_LSB +: 2];
		src = acl_source_t'(pwdata_in[`ACL_CMD_SRC_LSB +: 2]);
		enc = pwdata_in[`ACL_CMD_ENC_BIT];
		// Sensitive tables only from security management, encrypted
		src_ok = acl_sensitive(tbl) ? (src == ACL_SRC_SECURITY && enc) :
			(src == ACL_SRC_ASSET);
		prod_wr = 1'b0;
		commit = psel_in && penable_in && s_q.pready && pwrite_in;
		// One wait state, answer flopped with the address of the access phase
		s_d.pready = psel_in && penable_in && !s_q.pready;
		s_d.pslverr = 1'b0;
		if (s_d.pready) begin
			s_d.pslverr = !acl_mapped(paddr_in);
			s_d.prdata = pwrite_in ? 32'h0000_0000 : rd_word;
		end
		// Writes and commands land only at the edge that completes the access
		if (commit) begin
			case (paddr_in)
				`ACL_OFS_ARG0: s_d.arg0 = pwdata_in;
				`ACL_OFS_ARG1: s_d.arg1 = pwdata_in;
				`ACL_OFS_ARG2: s_d.arg2 = pwdata_in;
				`ACL_OFS_DATE: s_d.today = pwdata_in[15:0];
				`ACL_OFS_CMD: begin
					s_d.result = ACL_RS_OK;
					case (op)
						// Move to the requested operating state
						ACL_OP_BEGIN: begin
							s_d.op_state = acl_op_state_t'(pwdata_in[`ACL_CMD_ARG_LSB +: 2]);
						end
						// Medium authentication: state, then card codes
						ACL_OP_AUTH: begin
							if (!acl_state_ok(op, s_q.op_state)) begin
								s_d.result = ACL_RS_STATE;
							end else if (!card_first[2]) begin
								s_d.result = ACL_RS_NOMATCH;
							end else begin
								s_d.res0 = s_q.ro_key[cidx];
								s_d.res1 = s_q.rw_key[cidx];
								// Secure mode adds a session code that a replay cannot reuse
								s_d.res2 = s_q.arg2[0] ? auth_mac : 32'h0000_0000;
								s_d.sess = s_q.sess + 32'h1;
							end
						end
						// Sealing: state, then open-batch limit
						ACL_OP_SEAL: begin
							if (!acl_state_ok(op, s_q.op_state)) begin
								s_d.result = ACL_RS_STATE;
							end else if (s_q.open_batches >= s_q.batch_limit) begin
								s_d.result = ACL_RS_LIMIT;
							end else begin
								// Sequence number advances only on a seal that is given
								s_d.seq = seq_n;
								s_d.res0 = seal;
								s_d.res1 = ref_enc;
								s_d.header = hdr_n;
								s_d.res2 = hdr_n;
							end
						end
						// Poll closes the current batch and opens the next
						ACL_OP_POLL: begin
							if (s_q.open_batches == `ACL_OPEN_MAX) begin
								s_d.result = ACL_RS_LIMIT;
							end else begin
								s_d.open_batches = s_q.open_batches + 8'h01;
								s_d.header = s_q.seq;
							end
						end
						// Delete retires one open batch
						ACL_OP_DELETE: begin
							if (s_q.open_batches == 8'h00) begin
								s_d.result = ACL_RS_NOMATCH;
							end else begin
								s_d.open_batches = s_q.open_batches - 8'h01;
							end
						end
						// Table load: table id, then source, then load order
						ACL_OP_LOAD: begin
							if (tbl > ACL_TB_INSTANCES) begin
								s_d.result = ACL_RS_OPCODE;
							end else if (!src_ok) begin
								s_d.result = ACL_RS_SOURCE;
							end else if (tbl >= ACL_TB_CARD &&
									s_q.loaded[2:0] != `ACL_BASE_LOADED) begin
								s_d.result = ACL_RS_ORDER;
							end else begin
								s_d.loaded[tbl[2:0]] = 1'b1;
								case (tbl)
									// Configuration carries the batch limit and the seal key
									ACL_TB_CONFIG: begin
										s_d.batch_limit = s_q.arg0[7:0];
										s_d.cfg_key = s_q.arg1;
									end
									// Card codes record with its validity window
									ACL_TB_CARD: begin
										s_d.card[idx].used = 1'b1;
										s_d.card[idx].codes = s_q.arg0;
										s_d.card[idx].from_date = s_q.arg2[31:16];
										s_d.card[idx].until_date = s_q.arg2[15:0];
									end
									// Read-only and read/write access keys side by side
									ACL_TB_ACCESS_KEYS: begin
										s_d.ro_key[idx] = s_q.arg0;
										s_d.rw_key[idx] = s_q.arg1;
									end
									ACL_TB_PRODUCTS: prod_wr = 1'b1;
									ACL_TB_PRODUCT_KEYS: s_d.pkey[idx] = s_q.arg0;
									ACL_TB_INSTANCES: s_d.inst[idx] = s_q.arg0;
									default: s_d.loaded = s_d.loaded;
								endcase
							end
						end
						// Product lookup: state, then ordered table search
						ACL_OP_PRODUCT: begin
							if (!acl_state_ok(op, s_q.op_state)) begin
								s_d.result = ACL_RS_STATE;
							end else if (!prod_hit) begin
								s_d.result = ACL_RS_NOMATCH;
							end else begin
								// Created products take the physical identity if own, else a proxy; others return zero
								s_d.res0 = s_q.pkey[prod_idx];
								s_d.res1 = !prod_create ? 32'h0000_0000 :
									(prod_own ? PHYS_ID : s_q.inst[prod_idx]);
								s_d.res2 = {28'h0000000, prod_create, prod_own, prod_idx};
							end
						end
						// Unknown opcodes are refused
						default: s_d.result = ACL_RS_OPCODE;
					endcase
				end
				// Read-only and unmapped offsets ignore writes
				default: s_d.result = s_q.result;
			endcase
		end
	end

	// State register
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			s_q <= `ACL_RST_STATE;
		end else begin
			s_q <= s_d;
		end
	end
endmodule

// ### tb/acl_lookup_checker.sv
// Bus protocol assertions for the criteria lookup block
`timescale 1ns/1ns
module acl_lookup_checker (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_in,
	// Bus
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] prdata_out,
	input wire logic pready_out,
	input wire logic pslverr_out
);
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);
	// Access phase still waiting for its answer
	wire logic acc = psel_in && penable_in && !pready_out;
	a_one_wait: assert property (acc |=> pready_out) else $error("answer late");
	a_ready_cause: assert property (pready_out |-> $past(acc) && !$past(pready_out))
		else $error("answer without access");
	a_idle_quiet: assert property (!psel_in |=> !pready_out) else $error("answer while idle");
	a_err_unmapped: assert property (acc && paddr_in > 8'h28 |=> pslverr_out)
		else $error("no error");
	a_ok_mapped: assert property (acc && paddr_in <= 8'h28 && paddr_in[1:0] == 2'h0 |=> !pslverr_out)
		else $error("spurious error");
	a_err_ready: assert property (pslverr_out |-> pready_out) else $error("error alone");
	a_err_data: assert property (pslverr_out |-> prdata_out == 32'h0)
		else $error("error data");
	a_write_data: assert property (acc && pwrite_in |=> prdata_out == 32'h0)
		else $error("write data");
endmodule

bind acl_lookup acl_lookup_checker u_chk (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
	.psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
	.prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out));

// ### tb/acl_term.sv
// Terminal model: bus master that issues register transfers
`timescale 1ns/1ns
module acl_term (
	// Clock
	input wire logic sys_clk_in,
	// Requests
	output logic psel_out,
	output logic penable_out,
	output logic pwrite_out,
	output logic [7:0] paddr_out,
	output logic [31:0] pwdata_out,
	// Answers
	input wire logic [31:0] prdata_in,
	input wire logic pready_in,
	input wire logic pslverr_in
);
	// Idle bus from time zero
	initial begin
		psel_out = 1'b0;
		penable_out = 1'b0;
		pwrite_out = 1'b0;
		paddr_out = 8'h00;
		pwdata_out = 32'h0;
	end
	// Setup, then access held until ready is sampled high
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] r, output logic e, output bit ok);
		int n;
		n = 0;
		@(posedge sys_clk_in);
		psel_out <= 1'b1;
		pwrite_out <= w;
		paddr_out <= a;
		pwdata_out <= d;
		@(posedge sys_clk_in);
		penable_out <= 1'b1;
		do begin
			@(posedge sys_clk_in);
			n++;
		end while (pready_in !== 1'b1 && n < 50);
		r = prdata_in;
		e = pslverr_in;
		ok = (n < 50);
		psel_out <= 1'b0;
		penable_out <= 1'b0;
		pwdata_out <= ~d; // Stale data never looks valid
	endtask
endmodule

// ### tb/tb.sv
// Self-checking bench for the criteria lookup block
`timescale 1ns/1ns
`include "acl_cfg.svh"
module tb import acl_pkg::*; ;
	localparam logic [31:0] PHYS = 32'h0000_1234; // Arbitrary module identity
	localparam logic [7:0] CR = `ACL_OFS_CMD, A0 = `ACL_OFS_ARG0, A1 = `ACL_OFS_ARG1;
	localparam logic [7:0] A2 = `ACL_OFS_ARG2, ST = `ACL_OFS_STATUS, R0 = `ACL_OFS_RES0;
	localparam logic [7:0] R1 = `ACL_OFS_RES1, R2 = `ACL_OFS_RES2, DT = `ACL_OFS_DATE;
	localparam logic [7:0] SQ = `ACL_OFS_SEQ, LD = `ACL_OFS_LOADED;
	localparam acl_source_t AM = ACL_SRC_ASSET, SM = ACL_SRC_SECURITY;
	logic sys_clk_in, rst_in, psel, penable, pwrite, pready, pslverr, re;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rv, s1, e1, h1;
	int fails, compares;
	logic [15:0] dts [4] = '{16'h0005, 16'h0010, 16'h0020, 16'h0021};
	acl_result_t dx [4] = '{ACL_RS_NOMATCH, ACL_RS_OK, ACL_RS_OK, ACL_RS_NOMATCH};
	logic [31:0] prs [3] = '{32'h1122_335a, 32'h1122_ff5a, 32'h11ff_ff5a};
	logic [31:0] pfl [3] = '{32'h344, 32'h44, 32'h244};
	acl_lookup #(.PHYS_ID(PHYS)) DUT (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .psel_in(psel),
		.penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
		.prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr));
	acl_term term (.sys_clk_in(sys_clk_in), .psel_out(psel), .penable_out(penable),
		.pwrite_out(pwrite), .paddr_out(paddr), .pwdata_out(pwdata), .prdata_in(prdata),
		.pready_in(pready), .pslverr_in(pslverr));
	// Clock
	initial begin
		sys_clk_in = 1'b0;
		forever #5 sys_clk_in = ~sys_clk_in;
	end
	task automatic print_verdict();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	// One transfer; a hung bus ends the run
	task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d);
		bit ok;
		term.xfer(w, a, d, rv, re, ok);
		if (!ok) begin
			fails++;
			print_verdict();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xf(1'b1, a, d);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] x);
		xf(1'b0, a, 32'h0);
		chk(rv, x);
	endtask
	// Command, then its result code from the status word
	task automatic cmd(input acl_opcode_t o, input logic [3:0] a, input logic [1:0] i,
			input acl_source_t s, input logic e, input acl_result_t x);
		wr(CR, {13'h0, e, s, 6'h0, i, a, o});
		xf(1'b0, ST, 32'h0);
		chk(32'(rv[7:4]), 32'(x));
	endtask
	task automatic op(input acl_opcode_t o, input acl_result_t x);
		cmd(o, 4'h0, 2'h0, ACL_SRC_NONE, 1'b0, x);
	endtask
	task automatic ld(input logic [3:0] t, input logic [1:0] i, input acl_source_t s,
			input logic e, input acl_result_t x);
		cmd(ACL_OP_LOAD, t, i, s, e, x);
	endtask
	task automatic pq(input logic [31:0] sel, input logic [31:0] a1, input acl_result_t x,
			input logic [31:0] k, input logic [31:0] id, input logic [3:0] r2);
		wr(A0, sel);
		wr(A1, a1);
		op(ACL_OP_PRODUCT, x);
		if (x == ACL_RS_OK) begin
			rc(R0, k);
			rc(R1, id);
			rc(R2, 32'(r2));
		end
	endtask
	// Main sequence
	initial begin
		fails = 0;
		compares = 0;
		rst_in = 1'b1;
		repeat (4) @(posedge sys_clk_in);
		rst_in <= 1'b0;
		rc(ST, 32'h0);
		rc(LD, 32'h0);
		xf(1'b0, 8'h40, 32'h0);
		chk(32'(re), 32'h1);
		chk(rv, 32'h0);
		wr(ST, 32'hffff_ffff);
		rc(ST, 32'h0);
		op(acl_opcode_t'(4'h8), ACL_RS_OPCODE);
		op(ACL_OP_SEAL, ACL_RS_STATE);
		ld(4'h3, 2'h0, AM, 1'b0, ACL_RS_ORDER);
		ld(4'h0, 2'h0, AM, 1'b1, ACL_RS_SOURCE);
		ld(4'h0, 2'h0, SM, 1'b0, ACL_RS_SOURCE);
		rc(LD, 32'h0);
		wr(A0, 32'h1);
		for (int t = 0; t < 3; t++) begin
			ld(4'(t), 2'h0, SM, 1'b1, ACL_RS_OK);
		end
		rc(LD, 32'h7);
		// Card codes: one dated record, one open record
		wr(A2, 32'h0010_0020);
		wr(A0, 32'h1234_5678);
		ld(4'h3, 2'h0, SM, 1'b1, ACL_RS_SOURCE);
		ld(4'h3, 2'h0, AM, 1'b0, ACL_RS_OK);
		wr(A2, 32'h0);
		wr(A0, 32'h55);
		ld(4'h3, 2'h1, AM, 1'b0, ACL_RS_OK);
		for (int i = 0; i < 2; i++) begin
			wr(A0, 32'ha0a0 + 32'(i));
			wr(A1, 32'hb0b0 + 32'(i));
			ld(4'h4, 2'(i), AM, 1'b0, ACL_RS_SOURCE);
			ld(4'h4, 2'(i), SM, 1'b1, ACL_RS_OK);
		end
		// Accepted products, product keys and a proxy identity
		for (int i = 0; i < 3; i++) begin
			wr(A0, prs[i]);
			wr(A1, pfl[i]);
			ld(4'h5, 2'(i), SM, 1'b1, ACL_RS_SOURCE);
			ld(4'h5, 2'(i), AM, 1'b0, ACL_RS_OK);
			wr(A0, 32'hc0de_0000 + 32'(i));
			ld(4'h6, 2'(i), AM, 1'b0, ACL_RS_SOURCE);
			ld(4'h6, 2'(i), SM, 1'b1, ACL_RS_OK);
		end
		wr(A0, 32'h77);
		ld(4'h7, 2'h2, SM, 1'b1, ACL_RS_OK);
		ld(4'h8, 2'h0, SM, 1'b1, ACL_RS_OPCODE);
		rc(LD, 32'hff);
		// Gating of sealing and authentication in every state
		wr(A0, 32'h55);
		wr(DT, 32'hffff);
		for (int s = 0; s < 4; s++) begin
			cmd(ACL_OP_BEGIN, 4'(s), 2'h0, ACL_SRC_NONE, 1'b0, ACL_RS_OK);
			chk(32'(rv[1:0]), 32'(s));
			op(ACL_OP_SEAL, s >= 2 ? ACL_RS_OK : ACL_RS_STATE);
			op(ACL_OP_AUTH, s == 3 ? ACL_RS_OK : ACL_RS_STATE);
		end
		rc(R0, 32'ha0a1);
		rc(R1, 32'hb0b1);
		rc(R2, 32'h0);
		rc(SQ, 32'h2);
		// Validity window, then a refused lookup keeps earlier results
		wr(A0, 32'h1234_5678);
		for (int i = 0; i < 4; i++) begin
			wr(DT, 32'(dts[i]));
			op(ACL_OP_AUTH, dx[i]);
		end
		rc(R0, 32'ha0a0);
		wr(DT, 32'h10);
		wr(A0, 32'h1234_5679);
		op(ACL_OP_AUTH, ACL_RS_NOMATCH);
		wr(A0, 32'h1234_5678);
		wr(A2, 32'h1);
		op(ACL_OP_AUTH, ACL_RS_OK);
		xf(1'b0, R2, 32'h0);
		chk(32'(rv != 32'h0), 32'h1);
		s1 = rv;
		op(ACL_OP_AUTH, ACL_RS_OK);
		xf(1'b0, R2, 32'h0);
		chk(32'(rv != s1), 32'h1);
		// Sealing: sequence, reference encryption, header, batch limit
		wr(A1, 32'h1234);
		wr(A2, 32'h44);
		op(ACL_OP_SEAL, ACL_RS_OK);
		rc(SQ, 32'h3);
		xf(1'b0, R0, 32'h0);
		s1 = rv;
		xf(1'b0, R1, 32'h0);
		e1 = rv;
		xf(1'b0, R2, 32'h0);
		h1 = rv;
		chk(32'(e1 != 32'h1234), 32'h1);
		wr(A2, 32'h45);
		op(ACL_OP_SEAL, ACL_RS_OK);
		rc(SQ, 32'h4);
		xf(1'b0, R0, 32'h0);
		chk(32'(rv != s1), 32'h1);
		xf(1'b0, R1, 32'h0);
		chk(32'(rv != e1), 32'h1);
		xf(1'b0, R2, 32'h0);
		chk(32'(rv != h1), 32'h1);
		op(ACL_OP_POLL, ACL_RS_OK);
		chk(32'(rv[15:8]), 32'h1);
		op(ACL_OP_SEAL, ACL_RS_LIMIT);
		rc(SQ, 32'h4);
		op(ACL_OP_DELETE, ACL_RS_OK);
		op(ACL_OP_DELETE, ACL_RS_NOMATCH);
		chk(32'(rv[15:8]), 32'h0);
		// Ordered product search with wildcards and issuer choice
		pq(prs[0], 32'h1144, ACL_RS_OK, 32'hc0de_0000, PHYS, 4'hc);
		pq(32'h1122_345a, 32'h1144, ACL_RS_OK, 32'hc0de_0001, 32'h0, 4'h1);
		pq(32'h1123_015a, 32'h1144, ACL_RS_OK, 32'hc0de_0002, 32'h77, 4'ha);
		pq(prs[0], 32'h9944, ACL_RS_NOMATCH, 32'h0, 32'h0, 4'h0);
		pq(prs[0], 32'h1_9944, ACL_RS_OK, 32'hc0de_0000, PHYS, 4'hc);
		pq(prs[0], 32'h1145, ACL_RS_NOMATCH, 32'h0, 32'h0, 4'h0);
		print_verdict();
	end
endmodule
